// ===== logic/ctp_pkg.sv
package ctp_pkg;

  // =========================================================
  // Timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int RECONF_MIN_NS = 320;
  localparam int RECONF_MIN_CYC = (RECONF_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CFG_LOAD_CYC = 64;
  localparam int CNT_W = 16;

  // =========================================================
  // Test access port
  localparam int IR_LEN = 4;
  localparam int DR_IDCODE_LEN = 32;
  localparam logic [3:0] IR_CAPTURE = 4'h1;
  localparam logic [3:0] IR_IDCODE = 4'h2;
  localparam logic [3:0] IR_BYPASS = 4'hF;
  // Arbitrary neutral identification value; bit 0 must stay one.
  localparam logic [31:0] IDCODE_VALUE = 32'h1234_5671;

  // =========================================================
  // Synchroniser lanes and their reset levels
  localparam int SYNC_W = 5;
  localparam int SY_TCK = 0;
  localparam int SY_TMS = 1;
  localparam int SY_TDI = 2;
  localparam int SY_RECONF = 3;
  localparam int SY_DONE = 4;
  localparam logic [4:0] SYNC_RESET = 5'h0E;

  typedef enum logic [15:0] {
    ST_RESET = 16'h0001,
    ST_IDLE = 16'h0002,
    ST_SEL_DR = 16'h0004,
    ST_CAP_DR = 16'h0008,
    ST_SH_DR = 16'h0010,
    ST_EX1_DR = 16'h0020,
    ST_PAUSE_DR = 16'h0040,
    ST_EX2_DR = 16'h0080,
    ST_UPD_DR = 16'h0100,
    ST_SEL_IR = 16'h0200,
    ST_CAP_IR = 16'h0400,
    ST_SH_IR = 16'h0800,
    ST_EX1_IR = 16'h1000,
    ST_PAUSE_IR = 16'h2000,
    ST_EX2_IR = 16'h4000,
    ST_UPD_IR = 16'h8000
  } ctp_state_t;

endpackage

// ===== logic/ctp_tap_if.sv
interface ctp_tap_if;
  logic tckRise;
  logic tms;
  logic testReset;
  logic captureDr;
  logic shiftDr;
  logic updateDr;
  logic captureIr;
  logic shiftIr;
  logic updateIr;

  modport fsm (
    input tckRise,
    input tms,
    output testReset,
    output captureDr,
    output shiftDr,
    output updateDr,
    output captureIr,
    output shiftIr,
    output updateIr
  );

  modport core (
    output tckRise,
    output tms,
    input testReset,
    input captureDr,
    input shiftDr,
    input updateDr,
    input captureIr,
    input shiftIr,
    input updateIr
  );
endinterface

// ===== logic/ctp_tap_fsm.sv
module ctp_tap_fsm (
  input wire logic sys_clk,
  input wire logic rst_n,
  ctp_tap_if.fsm tap
);

  // =========================================================
  // Controller state
  ctp_pkg::ctp_state_t state_q;
  ctp_pkg::ctp_state_t state_d;

  always_comb
  begin
    state_d = state_q;
    if (tap.tckRise)
    begin
      case (state_q)
        ctp_pkg::ST_RESET: state_d = tap.tms ? ctp_pkg::ST_RESET : ctp_pkg::ST_IDLE;
        ctp_pkg::ST_IDLE: state_d = tap.tms ? ctp_pkg::ST_SEL_DR : ctp_pkg::ST_IDLE;
        ctp_pkg::ST_SEL_DR: state_d = tap.tms ? ctp_pkg::ST_SEL_IR : ctp_pkg::ST_CAP_DR;
        ctp_pkg::ST_CAP_DR: state_d = tap.tms ? ctp_pkg::ST_EX1_DR : ctp_pkg::ST_SH_DR;
        ctp_pkg::ST_SH_DR: state_d = tap.tms ? ctp_pkg::ST_EX1_DR : ctp_pkg::ST_SH_DR;
        ctp_pkg::ST_EX1_DR: state_d = tap.tms ? ctp_pkg::ST_UPD_DR : ctp_pkg::ST_PAUSE_DR;
        ctp_pkg::ST_PAUSE_DR: state_d = tap.tms ? ctp_pkg::ST_EX2_DR : ctp_pkg::ST_PAUSE_DR;
        ctp_pkg::ST_EX2_DR: state_d = tap.tms ? ctp_pkg::ST_UPD_DR : ctp_pkg::ST_SH_DR;
        ctp_pkg::ST_UPD_DR: state_d = tap.tms ? ctp_pkg::ST_SEL_DR : ctp_pkg::ST_IDLE;
        ctp_pkg::ST_SEL_IR: state_d = tap.tms ? ctp_pkg::ST_RESET : ctp_pkg::ST_CAP_IR;
        ctp_pkg::ST_CAP_IR: state_d = tap.tms ? ctp_pkg::ST_EX1_IR : ctp_pkg::ST_SH_IR;
        ctp_pkg::ST_SH_IR: state_d = tap.tms ? ctp_pkg::ST_EX1_IR : ctp_pkg::ST_SH_IR;
        ctp_pkg::ST_EX1_IR: state_d = tap.tms ? ctp_pkg::ST_UPD_IR : ctp_pkg::ST_PAUSE_IR;
        ctp_pkg::ST_PAUSE_IR: state_d = tap.tms ? ctp_pkg::ST_EX2_IR : ctp_pkg::ST_PAUSE_IR;
        ctp_pkg::ST_EX2_IR: state_d = tap.tms ? ctp_pkg::ST_UPD_IR : ctp_pkg::ST_SH_IR;
        ctp_pkg::ST_UPD_IR: state_d = tap.tms ? ctp_pkg::ST_SEL_DR : ctp_pkg::ST_IDLE;
        default: state_d = ctp_pkg::ST_RESET;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      state_q <= ctp_pkg::ST_RESET;
    else
      state_q <= state_d;
  end

  // =========================================================
  // Decoded state flags
  assign tap.testReset = (state_q == ctp_pkg::ST_RESET);
  assign tap.captureDr = (state_q == ctp_pkg::ST_CAP_DR);
  assign tap.shiftDr = (state_q == ctp_pkg::ST_SH_DR);
  assign tap.updateDr = (state_q == ctp_pkg::ST_UPD_DR);
  assign tap.captureIr = (state_q == ctp_pkg::ST_CAP_IR);
  assign tap.shiftIr = (state_q == ctp_pkg::ST_SH_IR);
  assign tap.updateIr = (state_q == ctp_pkg::ST_UPD_IR);

endmodule

// ===== logic/ctp_config_port.sv
module ctp_config_port #(
  parameter int IR_W = ctp_pkg::IR_LEN,
  parameter int LOAD_CYCLES = ctp_pkg::CFG_LOAD_CYC,
  parameter int RECONF_MIN_CYCLES = ctp_pkg::RECONF_MIN_CYC,
  parameter logic [31:0] IDCODE = ctp_pkg::IDCODE_VALUE
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic tckPin,
  input wire logic tmsPin,
  input wire logic tdiPin,
  input wire logic reconfReqPinN,
  input wire logic cfgDoneIn,
  input wire logic globalControlInput,
  output logic tdoOut,
  output logic tdoOeN,
  output logic cfgDoneOut,
  output logic cfgDoneOeN,
  output logic userMode,
  output logic globalControlOut
);

  // =========================================================
  // Pin synchronisers
  // The pull-ups are modelled by resetting the mode select and data
  // lanes to one, so the test logic sees a one before any drive.
  logic [ctp_pkg::SYNC_W-1:0] syncA_q;
  logic [ctp_pkg::SYNC_W-1:0] syncB_q;
  logic tckPrev_q;
  logic reconfPrev_q;
  logic gctlA_q;
  logic gctlB_q;

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      syncA_q <= ctp_pkg::SYNC_RESET;
      syncB_q <= ctp_pkg::SYNC_RESET;
      tckPrev_q <= 1'b0;
      reconfPrev_q <= 1'b1;
      gctlA_q <= 1'b0;
      gctlB_q <= 1'b0;
      globalControlOut <= 1'b0;
    end
    else
    begin
      syncA_q <= {cfgDoneIn, reconfReqPinN, tdiPin, tmsPin, tckPin};
      syncB_q <= syncA_q;
      tckPrev_q <= syncB_q[ctp_pkg::SY_TCK];
      reconfPrev_q <= syncB_q[ctp_pkg::SY_RECONF];
      gctlA_q <= globalControlInput;
      gctlB_q <= gctlA_q;
      globalControlOut <= gctlB_q;
    end
  end

  wire tck = syncB_q[ctp_pkg::SY_TCK];
  wire tms = syncB_q[ctp_pkg::SY_TMS];
  wire tdi = syncB_q[ctp_pkg::SY_TDI];
  wire reconfN = syncB_q[ctp_pkg::SY_RECONF];
  wire cfgDonePin = syncB_q[ctp_pkg::SY_DONE];
  wire tckRise = tck & ~tckPrev_q;
  wire tckFall = ~tck & tckPrev_q;

  // =========================================================
  // Controller
  ctp_tap_if tapBus ();

  assign tapBus.tckRise = tckRise;
  assign tapBus.tms = tms;

  ctp_tap_fsm uFsm (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .tap(tapBus.fsm)
  );

  // =========================================================
  // Instruction and data registers
  logic [IR_W-1:0] irShift_q;
  logic [IR_W-1:0] ir_q;
  logic [31:0] idShift_q;
  logic bypass_q;

  wire selIdcode = (ir_q == IR_W'(ctp_pkg::IR_IDCODE));
  wire [IR_W-1:0] irShiftNext = {tdi, irShift_q[IR_W-1:1]};
  wire [31:0] idShiftNext = {tdi, idShift_q[31:1]};
  wire drSerialBit = selIdcode ? idShift_q[0] : bypass_q;

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irShift_q <= '0;
      ir_q <= IR_W'(ctp_pkg::IR_IDCODE);
      idShift_q <= '0;
      bypass_q <= 1'b0;
    end
    else if (tckRise)
    begin
      if (tapBus.testReset)
        ir_q <= IR_W'(ctp_pkg::IR_IDCODE);
      else if (tapBus.updateIr)
        ir_q <= irShift_q;
      if (tapBus.captureIr)
        irShift_q <= IR_W'(ctp_pkg::IR_CAPTURE);
      else if (tapBus.shiftIr)
        irShift_q <= irShiftNext;
      if (tapBus.captureDr)
      begin
        idShift_q <= IDCODE;
        bypass_q <= 1'b0;
      end
      else if (tapBus.shiftDr && selIdcode)
        idShift_q <= idShiftNext;
      else if (tapBus.shiftDr)
        bypass_q <= tdi;
    end
  end

  // =========================================================
  // Serial output
  // Updating on the falling edge gives the far end half a test clock
  // of settling before it samples on the next rising edge.
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tdoOut <= 1'b0;
      tdoOeN <= 1'b1;
    end
    else if (tckFall)
    begin
      if (tapBus.shiftIr)
      begin
        tdoOut <= irShift_q[0];
        tdoOeN <= 1'b0;
      end
      else if (tapBus.shiftDr)
      begin
        tdoOut <= drSerialBit;
        tdoOeN <= 1'b0;
      end
      else
      begin
        tdoOut <= 1'b0;
        tdoOeN <= 1'b1;
      end
    end
  end

  // =========================================================
  // Configuration sequencing
  // Only the load sequencer and the user mode flag listen to the reconfiguration
  // pin; the test port and the global control output keep their state across it.
  logic [ctp_pkg::CNT_W-1:0] lowCount_q;
  logic [ctp_pkg::CNT_W-1:0] loadCount_q;
  logic cfgLoaded_q;

  wire pulseLongEnough = (lowCount_q >= ctp_pkg::CNT_W'(RECONF_MIN_CYCLES));
  wire reconfStart = reconfN & ~reconfPrev_q & pulseLongEnough;
  wire loadDone = (loadCount_q >= ctp_pkg::CNT_W'(LOAD_CYCLES - 1));

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      lowCount_q <= '0;
    else if (reconfN)
      lowCount_q <= '0;
    else if (!pulseLongEnough)
      lowCount_q <= lowCount_q + 1'b1;
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      loadCount_q <= '0;
      cfgLoaded_q <= 1'b0;
    end
    else if (reconfStart)
    begin
      loadCount_q <= '0;
      cfgLoaded_q <= 1'b0;
    end
    else if (!cfgLoaded_q)
    begin
      loadCount_q <= loadCount_q + 1'b1;
      cfgLoaded_q <= loadDone;
    end
  end

  // =========================================================
  // Done pin and user mode
  // The wired level is read back, so an external party holding the
  // line low keeps the device out of user mode.
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cfgDoneOut <= 1'b0;
      cfgDoneOeN <= 1'b0;
      userMode <= 1'b0;
    end
    else
    begin
      cfgDoneOut <= 1'b0;
      cfgDoneOeN <= cfgLoaded_q;
      userMode <= cfgLoaded_q & cfgDonePin & ~reconfStart;
    end
  end

endmodule

// ===== tb/ctp_tap_host.sv
module ctp_tap_host (
  input wire logic sys_clk,
  input wire logic tdoOut,
  output logic tckPin,
  output logic tmsPin,
  output logic tdiPin
);
  timeunit 1ns;
  timeprecision 1ns;
  logic tms = 1'b1;
  logic floatTms = 1'b0;
  initial tckPin = 1'b0;
  initial tdiPin = 1'b1;
  // ==========
  // Pins and one test clock period.
  // An undriven mode select reads as one through the pull-up.
  assign tmsPin = floatTms ? 1'b1 : tms;
  // Eight system cycles a bit: low for four, high for four.
  task automatic step(input logic m, input logic d, output logic o);
    @(posedge sys_clk) tckPin <= 1'b0;
    @(posedge sys_clk) tms <= m;
    tdiPin <= d;
    repeat (3) @(posedge sys_clk);
    tckPin <= 1'b1;
    repeat (2) @(posedge sys_clk);
    #1 o = tdoOut;
    @(posedge sys_clk);
  endtask
endmodule

// ===== tb/ctp_config_port_chk.sv
module ctp_config_port_chk (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic tckPin,
  input wire logic reconfReqPinN,
  input wire logic cfgDoneIn,
  input wire logic globalControlInput,
  input wire logic tdoOut,
  input wire logic tdoOeN,
  input wire logic cfgDoneOut,
  input wire logic cfgDoneOeN,
  input wire logic userMode,
  input wire logic globalControlOut
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  // ==========
  // Pin relations.
  a_tdo_after_fall:
    assert property ($changed(tdoOut) |-> !$past(tckPin) && !$past(tckPin, 3))
    else $error("Data out moved off a falling edge.");
  a_oe_after_fall:
    assert property ($changed(tdoOeN) |-> !$past(tckPin) && !$past(tckPin, 3))
    else $error("Data out enable moved off a falling edge.");
  a_tdo_idle_zero:
    assert property (tdoOeN |-> !tdoOut)
    else $error("Released data out carries a level.");
  a_done_open_drain:
    assert property (!cfgDoneOut)
    else $error("Done pin data drives high.");
  a_user_needs_done:
    assert property ($rose(userMode) |-> cfgDoneOeN && $past(cfgDoneIn, 3))
    else $error("User mode entered with done pin low.");
  a_reconf_on_rise:
    assert property ($fell(userMode) |-> reconfReqPinN && $past(reconfReqPinN))
    else $error("User mode left without a request rise.");
  a_load_pulls_done:
    assert property ($fell(userMode) |=> (!cfgDoneOeN) [*8])
    else $error("Done pin not pulled low while loading.");
  a_gc_untouched:
    assert property (1'b1 |-> ##3 globalControlOut == $past(globalControlInput, 3))
    else $error("Global control path disturbed.");
endmodule

bind ctp_config_port ctp_config_port_chk u_chk (
  .sys_clk(sys_clk), .rst_n(rst_n), .tckPin(tckPin),
  .reconfReqPinN(reconfReqPinN), .cfgDoneIn(cfgDoneIn),
  .globalControlInput(globalControlInput), .tdoOut(tdoOut),
  .tdoOeN(tdoOeN), .cfgDoneOut(cfgDoneOut), .cfgDoneOeN(cfgDoneOeN),
  .userMode(userMode), .globalControlOut(globalControlOut)
);

// ===== tb/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic reqN = 1'b1;
  logic extHold = 1'b0;
  logic gci = 1'b0;
  logic tck, tms, tdi, tdo, tdoOeN, cfgDoneOut, cfgDoneOeN, userMode, gco, o;
  logic donePin;
  logic [31:0] got;
  logic [31:0] din;
  int seed = 38141;
  int mismatches = 0;
  int num_checks = 0;
  // The done pin is wired low by either party, else pulled up.
  assign donePin = (cfgDoneOeN === 1'b0 || extHold) ? 1'b0 : 1'b1;
  always #4 sys_clk = ~sys_clk;
  always @(posedge sys_clk) gci <= 1'($random(seed));
  ctp_tap_host host (.sys_clk(sys_clk), .tdoOut(tdo), .tckPin(tck), .tmsPin(tms), .tdiPin(tdi));
  ctp_config_port #(.LOAD_CYCLES(16), .RECONF_MIN_CYCLES(4)) DUT (
    .sys_clk(sys_clk), .rst_n(rst_n), .tckPin(tck), .tmsPin(tms), .tdiPin(tdi),
    .reconfReqPinN(reqN), .cfgDoneIn(donePin), .globalControlInput(gci),
    .tdoOut(tdo), .tdoOeN(tdoOeN), .cfgDoneOut(cfgDoneOut), .cfgDoneOeN(cfgDoneOeN),
    .userMode(userMode), .globalControlOut(gco)
  );
  // ==========
  // Helpers.
  task automatic test_done();
    $display("Checks %0d, mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
    begin
      $display("Test passed");
    end
    else
    begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("Error at %0t: got %h, expected %h", $time, g, e);
    end
  endtask
  task automatic wait_user(input logic lvl);
    for (int i = 0; i < 300 && userMode !== lvl; i++) @(posedge sys_clk) #1;
    chk(32'(userMode), 32'(lvl));
    if (userMode !== lvl)
    begin
      test_done();
    end
  endtask
  // Scan from idle back to idle, bit zero first.
  task automatic scan(input logic ir, input int n, input logic [31:0] d, output logic [31:0] q);
    q = '0;
    host.step(1'b1, 1'b0, o);
    if (ir)
    begin
      host.step(1'b1, 1'b0, o);
    end
    repeat (2) host.step(1'b0, 1'b0, o);
    for (int k = 0; k < n; k++)
    begin
      host.step(k == n - 1, d[k], o);
      q[k] = o;
    end
    host.step(1'b1, 1'b0, o);
    host.step(1'b0, 1'b0, o);
  endtask
  // The one-bit path returns its captured zero, then the input delayed by one.
  function automatic logic [31:0] bypass_exp(input logic [31:0] d, input int n);
    return {d[30:0], 1'b0} & ((32'h0000_0001 << n) - 32'h0000_0001);
  endfunction
  // ==========
  // Main sequence.
  initial
  begin
    repeat (6) @(posedge sys_clk);
    chk(32'(tdoOeN), 32'h0000_0001);
    chk(32'(cfgDoneOeN), 32'h0000_0000);
    rst_n <= 1'b1;
    wait_user(1'b1);
    chk(32'(cfgDoneOeN), 32'h0000_0001);
    host.step(1'b0, 1'b0, o);
    scan(1'b1, 4, 32'h0000_000F, got);
    chk(got, 32'h0000_0001);
    // Bypass is loaded first, so five steps with the mode select read as one reach test logic reset and bring back the identity path.
    host.floatTms <= 1'b1;
    repeat (5) host.step(1'b0, 1'b0, o);
    host.floatTms <= 1'b0;
    host.step(1'b0, 1'b0, o);
    scan(1'b0, 32, 32'hFFFF_FFFF, got);
    chk(got, ctp_pkg::IDCODE_VALUE);
    chk(32'(tdoOeN), 32'h0000_0001);
    scan(1'b1, 4, 32'h0000_000F, got);
    chk(got, 32'h0000_0001);
    repeat (3)
    begin
      din = $random(seed);
      scan(1'b0, 16, din, got);
      chk(got, bypass_exp(din, 16));
    end
    // A pulse shorter than the minimum must be ignored.
    reqN <= 1'b0;
    repeat (2) @(posedge sys_clk);
    reqN <= 1'b1;
    repeat (20) @(posedge sys_clk);
    #1 chk(32'(userMode), 32'h0000_0001);
    reqN <= 1'b0;
    repeat (8) @(posedge sys_clk);
    reqN <= 1'b1;
    wait_user(1'b0);
    // The hold starts once loading runs, so leaving user mode stays tied to the request.
    extHold <= 1'b1;
    repeat (150) @(posedge sys_clk);
    #1 chk(32'(userMode), 32'h0000_0000);
    extHold <= 1'b0;
    wait_user(1'b1);
    din = $random(seed);
    scan(1'b0, 8, din, got);
    chk(got, bypass_exp(din, 8));
    test_done();
  end
endmodule
